// ### verilog/tteq_pkg.sv
// Constants for the two-thread event counter qualifier: register map,
// field positions, reset values and event class codes.
// Assumes a 12-bit register index space reached through a register port.
`default_nettype none

package tteq_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] TTEQ_CFG_BASE = 12'h360;
  localparam logic [11:0] TTEQ_PRECISE_CFG_LP0 = 12'h370;
  localparam logic [11:0] TTEQ_PRECISE_CFG_LP1 = 12'h371;
  localparam logic [11:0] TTEQ_ESEL_BASE = 12'h3A0;
  localparam logic [11:0] TTEQ_CTR_BASE = 12'h300;
  localparam logic [11:0] TTEQ_SAMPLE_EN_ADDR = 12'h3C0;
  localparam int TTEQ_PRECISE_IDX_LP0 =
    int'(TTEQ_PRECISE_CFG_LP0 - TTEQ_CFG_BASE);
  localparam int TTEQ_PRECISE_IDX_LP1 =
    int'(TTEQ_PRECISE_CFG_LP1 - TTEQ_CFG_BASE);
  localparam int TTEQ_NUM_CTR = 18;
  localparam int TTEQ_CTR_W = 40;

  // ==========================================================
  // counter configuration fields
  localparam int TTEQ_CFG_ENABLE_BIT = 12;
  localparam int TTEQ_CFG_COMPARE_BIT = 18;
  localparam int TTEQ_CFG_COMPL_BIT = 19;
  localparam int TTEQ_CFG_THR_LSB = 20;
  localparam int TTEQ_CFG_EDGE_BIT = 24;
  localparam logic [3:0] TTEQ_THR_ALWAYS = 4'hF;
  localparam logic [31:0] TTEQ_CFG_RESET = 32'h0000_0000;

  // ==========================================================
  // event select fields
  localparam int TTEQ_Q_LP1_USR = 0;
  localparam int TTEQ_Q_LP1_OS = 1;
  localparam int TTEQ_Q_LP0_USR = 2;
  localparam int TTEQ_Q_LP0_OS = 3;
  localparam int TTEQ_ESEL_MASK_LSB = 9;
  localparam int TTEQ_ESEL_CLASS_LSB = 25;
  localparam int TTEQ_RUNNING_MASK_BIT = 0;
  localparam logic [31:0] TTEQ_ESEL_RESET = 32'h0000_0000;

  // ==========================================================
  // precise sampling enable fields
  localparam int TTEQ_SE_OWN_BIT = 25;
  localparam int TTEQ_SE_OTHER_BIT = 26;

  // ==========================================================
  // event class codes (plain defaults)
  typedef logic [5:0] tteq_class_t;
  localparam tteq_class_t TTEQ_CLASS_NONE = 6'h00;
  localparam tteq_class_t TTEQ_CLASS_POWER = 6'h01;
  localparam tteq_class_t TTEQ_CLASS_EXEC = 6'h02;
  localparam tteq_class_t TTEQ_CLASS_FRONT = 6'h03;
  localparam tteq_class_t TTEQ_CLASS_REPLAY = 6'h04;

  localparam logic [1:0] TTEQ_CPL_KERNEL = 2'h0;

endpackage : tteq_pkg

`default_nettype wire

// ### verilog/tteq_qual_if.sv
// Interface between the counter top and one per-counter qualifier.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface tteq_qual_if;
  logic [31:0] cfg;
  logic [31:0] esel;
  logic [3:0] evt_count;
  logic evt_thread;
  logic evt_ts;
  logic [1:0][1:0] lp_cpl;
  logic [1:0] lp_halted;
  logic powered;
  logic cmp_prev;
  logic [3:0] inc;
  logic cmp_now;
  logic [1:0] precise_hit;

  modport qual (
    input cfg, esel, evt_count, evt_thread, evt_ts, lp_cpl, lp_halted,
    input powered, cmp_prev,
    output inc, cmp_now, precise_hit
  );
  modport ctl (
    output cfg, esel, evt_count, evt_thread, evt_ts, lp_cpl, lp_halted,
    output powered, cmp_prev,
    input inc, cmp_now, precise_hit
  );
endinterface : tteq_qual_if

`default_nettype wire

// ### verilog/tteq_qual.sv
// Per-counter qualification: thread and privilege gating, threshold
// filter and precise-sample hit. Purely combinational.
// Assumes thread state inputs are already on the core clock.
`timescale 1ns/1ps
`default_nettype none

module tteq_qual
  import tteq_pkg::*;
(
  // link to the counter top
  tteq_qual_if.qual q
);

  // ==========================================================
  // qualification helpers
  function automatic logic ts_ok(input logic [3:0] f, input logic lp,
                                 input logic [1:0] cpl);
    logic kern;
    kern = (cpl == TTEQ_CPL_KERNEL);
    if (lp) begin
      ts_ok = kern ? f[TTEQ_Q_LP1_OS] : f[TTEQ_Q_LP1_USR];
    end else begin
      ts_ok = kern ? f[TTEQ_Q_LP0_OS] : f[TTEQ_Q_LP0_USR];
    end
  endfunction : ts_ok

  function automatic logic ti_ok(input logic [3:0] f,
                                 input logic [1:0][1:0] cpl);
    logic u0, k0, u1, k1, any_u, any_k;
    u0 = f[TTEQ_Q_LP0_USR];
    k0 = f[TTEQ_Q_LP0_OS];
    u1 = f[TTEQ_Q_LP1_USR];
    k1 = f[TTEQ_Q_LP1_OS];
    any_u = (cpl[0] != TTEQ_CPL_KERNEL) || (cpl[1] != TTEQ_CPL_KERNEL);
    any_k = (cpl[0] == TTEQ_CPL_KERNEL) || (cpl[1] == TTEQ_CPL_KERNEL);
    if ((u0 && k0) || (u1 && k1) || (u0 && k1) || (k0 && u1)) begin
      ti_ok = 1'b1;
    end else if (u0 || u1) begin
      ti_ok = any_u;
    end else if (k0 || k1) begin
      ti_ok = any_k;
    end else begin
      ti_ok = 1'b0;
    end
  endfunction : ti_ok

  // ==========================================================
  // decision
  logic [3:0] flags;
  tteq_class_t cls;
  logic [3:0] thr;
  logic en, cmp_en, compl, edge_en, running, qual, always_true, precise;
  logic [3:0] raw;

  always_comb begin
    flags = q.esel[TTEQ_Q_LP0_OS:TTEQ_Q_LP1_USR];
    cls = q.esel[TTEQ_ESEL_CLASS_LSB +: 6];
    thr = q.cfg[TTEQ_CFG_THR_LSB +: 4];
    en = q.cfg[TTEQ_CFG_ENABLE_BIT];
    cmp_en = q.cfg[TTEQ_CFG_COMPARE_BIT];
    compl = q.cfg[TTEQ_CFG_COMPL_BIT];
    edge_en = q.cfg[TTEQ_CFG_EDGE_BIT];
    running = (cls == TTEQ_CLASS_POWER) &&
              q.esel[TTEQ_ESEL_MASK_LSB + TTEQ_RUNNING_MASK_BIT];
    // ts events look only at the source thread's flags
    qual = q.evt_ts ? ts_ok(flags, q.evt_thread, q.lp_cpl[q.evt_thread])
                    : ti_ok(flags, q.lp_cpl);
    if (running) begin
      // one count per non-halted thread, each under its own flags
      raw = {3'h0, ~q.lp_halted[0] & ts_ok(flags, 1'b0, q.lp_cpl[0])} +
            {3'h0, ~q.lp_halted[1] & ts_ok(flags, 1'b1, q.lp_cpl[1])};
    end else begin
      raw = qual ? q.evt_count : 4'h0;
    end
    always_true = cmp_en && compl && (thr == TTEQ_THR_ALWAYS);
    q.cmp_now = compl ? (raw <= thr) : (raw > thr);
    if (!en || cls == TTEQ_CLASS_NONE) begin
      q.inc = 4'h0;
    end else if (always_true) begin
      // qualification ignored; runs while monitor is powered
      q.inc = {3'h0, q.powered};
    end else if (cmp_en) begin
      q.inc = {3'h0, edge_en ? (q.cmp_now & ~q.cmp_prev) : q.cmp_now};
    end else begin
      q.inc = raw;
    end
    precise = (cls == TTEQ_CLASS_EXEC) || (cls == TTEQ_CLASS_FRONT) ||
              (cls == TTEQ_CLASS_REPLAY);
    q.precise_hit[0] = en && precise && !running && qual &&
                       (q.evt_count != 4'h0) && (q.evt_thread == 1'b0);
    q.precise_hit[1] = en && precise && !running && qual &&
                       (q.evt_count != 4'h0) && (q.evt_thread == 1'b1);
  end

endmodule : tteq_qual

`default_nettype wire

// ### verilog/tteq_counter_qualifier.sv
// Event counter set of one core shared by two hardware threads, with
// thread/privilege qualification, threshold filter and precise sampling.
// Assumes thread inputs come from core logic on sys_clk; register
// accesses arrive on the register port together with the issuing thread.
//
// How it works
// - Sample enable bits 25 own, 26 other
// - Enable bits resolve relative to writing thread
// - Precise samples only for retirement classes
// - Precise counters at 370H lp0, 371H lp1
// - Event thread is initial identifier bit 0
// - Events are thread-specific or thread-independent
// - Specific events ignore other thread's flags
// - Specific: count by source thread's level flag
// - Independent: both flags or mixed counts always
// - Independent: user-only, kernel-only, none as levels
// - Running counts each non-halted thread's cycles
// - Compare, threshold 15, complement counts every clock while monitor is powered
// - Always-true filter ignores qualification flags
// - Any of 18 counters does non-sleep
// - Core power-saves only when both threads halted
// - Non-sleep counts while monitor is powered
// - Each core has its own counter set
// - Flags: bit0 lp1 usr .. bit3 lp0 os
// - Config bit 12 enables, cleared at reset
// - Complement: <= threshold counts, else > threshold
// - Threshold bits 20-23 used under compare
`timescale 1ns/1ps
`default_nettype none

module tteq_counter_qualifier
  import tteq_pkg::*;
#(
  parameter int NUM_CTR = TTEQ_NUM_CTR,
  parameter int CTR_W = TTEQ_CTR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_lp,
  output logic [63:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  // thread state
  input wire logic [1:0][1:0] lp_cpl,
  input wire logic [1:0] lp_halted,
  // event sources, one per counter
  input wire logic [NUM_CTR-1:0][3:0] evt_count,
  input wire logic [NUM_CTR-1:0] evt_src_id0,
  input wire logic [NUM_CTR-1:0] evt_ts,
  // results
  output logic [1:0] precise_sample,
  output logic core_power_save
);

  // ==========================================================
  // storage; one full set per core instance
  logic [31:0] cfg_q [NUM_CTR];
  logic [31:0] esel_q [NUM_CTR];
  logic [CTR_W-1:0] ctr_q [NUM_CTR];
  logic [NUM_CTR-1:0] cmp_prev_q;
  logic [1:0] sample_en_q;
  logic power_save_q;
  logic [63:0] rdata_q;
  logic ack_q, err_q;
  logic [1:0] sample_q;

  logic [3:0] inc_w [NUM_CTR];
  logic [NUM_CTR-1:0] cmp_now_w;
  logic [NUM_CTR-1:0][1:0] hit_w;
  logic powered;

  // ==========================================================
  // address decode
  logic hit_cfg, hit_esel, hit_ctr, hit_se;
  logic [11:0] idx_cfg, idx_esel, idx_ctr;

  always_comb begin
    idx_cfg = reg_addr - TTEQ_CFG_BASE;
    idx_esel = reg_addr - TTEQ_ESEL_BASE;
    idx_ctr = reg_addr - TTEQ_CTR_BASE;
    hit_cfg = (reg_addr >= TTEQ_CFG_BASE) &&
              (idx_cfg < 12'(NUM_CTR));
    hit_esel = (reg_addr >= TTEQ_ESEL_BASE) && (idx_esel < 12'(NUM_CTR));
    hit_ctr = (reg_addr >= TTEQ_CTR_BASE) && (idx_ctr < 12'(NUM_CTR));
    hit_se = (reg_addr == TTEQ_SAMPLE_EN_ADDR);
  end

  // ==========================================================
  // configuration and event select registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CTR; i++) begin
        cfg_q[i] <= TTEQ_CFG_RESET;
        esel_q[i] <= TTEQ_ESEL_RESET;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < NUM_CTR; i++) begin
        if (hit_cfg && idx_cfg == 12'(i)) begin
          cfg_q[i] <= reg_wdata[31:0];
        end
        if (hit_esel && idx_esel == 12'(i)) begin
          esel_q[i] <= reg_wdata[31:0];
        end
      end
    end
  end

  // ==========================================================
  // precise sampling enable, held per absolute thread
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_en_q <= 2'h0;
    end else if (reg_wr && hit_se) begin
      // writer's own bit lands on its thread, the other on its sibling
      sample_en_q[reg_lp] <= reg_wdata[TTEQ_SE_OWN_BIT];
      sample_en_q[~reg_lp] <= reg_wdata[TTEQ_SE_OTHER_BIT];
    end
  end

  // ==========================================================
  // per-counter qualifiers
  assign powered = ~&lp_halted && !power_save_q;

  for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
    tteq_qual_if qif();
    assign qif.cfg = cfg_q[g];
    assign qif.esel = esel_q[g];
    assign qif.evt_count = evt_count[g];
    assign qif.evt_thread = evt_src_id0[g];
    assign qif.evt_ts = evt_ts[g];
    assign qif.lp_cpl = lp_cpl;
    assign qif.lp_halted = lp_halted;
    assign qif.powered = powered;
    assign qif.cmp_prev = cmp_prev_q[g];
    assign inc_w[g] = qif.inc;
    assign cmp_now_w[g] = qif.cmp_now;
    assign hit_w[g] = qif.precise_hit;
    tteq_qual u_qual (
      .q(qif.qual)
    );
  end

  // ==========================================================
  // counters; a software write wins over an increment that cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CTR; i++) begin
        ctr_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CTR; i++) begin
        if (reg_wr && hit_ctr && idx_ctr == 12'(i)) begin
          ctr_q[i] <= reg_wdata[CTR_W-1:0];
        end else begin
          ctr_q[i] <= ctr_q[i] + CTR_W'(inc_w[i]);
        end
      end
    end
  end

  // edge filter memory of the threshold comparison
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_prev_q <= '0;
    end else begin
      cmp_prev_q <= cmp_now_w;
    end
  end

  // ==========================================================
  // precise sample requests: only the two dedicated counters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_q <= 2'h0;
    end else begin
      sample_q[0] <= sample_en_q[0] &&
                     hit_w[TTEQ_PRECISE_IDX_LP0][0];
      sample_q[1] <= sample_en_q[1] &&
                     hit_w[TTEQ_PRECISE_IDX_LP1][1];
    end
  end

  // ==========================================================
  // core power-saving state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_save_q <= 1'b0;
    end else begin
      power_save_q <= &lp_halted;
    end
  end

  // ==========================================================
  // register read path; unmapped addresses answer with error, data zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 64'h0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= reg_rd || reg_wr;
      err_q <= (reg_rd || reg_wr) &&
               !(hit_cfg || hit_esel || hit_ctr || hit_se);
      if (reg_rd) begin
        rdata_q <= 64'h0;
        for (int i = 0; i < NUM_CTR; i++) begin
          if (hit_cfg && idx_cfg == 12'(i)) begin
            rdata_q <= {32'h0, cfg_q[i]};
          end
          if (hit_esel && idx_esel == 12'(i)) begin
            rdata_q <= {32'h0, esel_q[i]};
          end
          if (hit_ctr && idx_ctr == 12'(i)) begin
            rdata_q <= 64'(ctr_q[i]);
          end
        end
        if (hit_se) begin
          // read back relative to the reading thread
          rdata_q[TTEQ_SE_OWN_BIT] <= sample_en_q[reg_lp];
          rdata_q[TTEQ_SE_OTHER_BIT] <= sample_en_q[~reg_lp];
        end
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign reg_err = err_q;
  assign precise_sample = sample_q;
  assign core_power_save = power_save_q;

endmodule : tteq_counter_qualifier

`default_nettype wire

// ### bench/tteq_thread_model.sv
// Behavioural model of the two hardware threads beside the qualifier.
// Assumes the bench changes its commands at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module tteq_thread_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // commands from the bench
  input wire logic [1:0][1:0] cmd_cpl,
  input wire logic [1:0] cmd_halt,
  input wire logic [3:0] halt_lag,
  // thread state to the core
  output logic [1:0][1:0] lp_cpl,
  output logic [1:0] lp_halted
);
  logic [1:0][3:0] wait_q;

  // ==========================================================
  // halt entry lags like a real pipeline drain, wake is at once
  always @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_halted <= 2'h3;
      wait_q <= '0;
      lp_cpl <= '0;
    end else begin
      lp_cpl <= cmd_cpl;
      for (int t = 0; t < 2; t++) begin
        if (!cmd_halt[t]) begin
          lp_halted[t] <= 1'b0;
          wait_q[t] <= halt_lag;
        end else if (wait_q[t] == 4'h0) begin
          lp_halted[t] <= 1'b1;
        end else begin
          wait_q[t] <= wait_q[t] - 4'h1;
        end
      end
    end
  end
endmodule : tteq_thread_model

`default_nettype wire

// ### bench/tteq_counter_qualifier_asserts.sv
// Concurrent checks on the qualifier's top-level ports.
// Assumes one core clock and the one-cycle register answer.
`timescale 1ns/1ps
`default_nettype none

module tteq_counter_qualifier_asserts
  import tteq_pkg::*;
#(
  parameter int NUM_CTR = TTEQ_NUM_CTR
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [63:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  // thread state and events
  input wire logic [1:0] lp_halted,
  input wire logic [NUM_CTR-1:0][3:0] evt_count,
  input wire logic [NUM_CTR-1:0] evt_src_id0,
  // results
  input wire logic [1:0] precise_sample,
  input wire logic core_power_save
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_ack_follows_req: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("register access not answered next cycle");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("answer without a request");
  a_err_with_ack: assert property (reg_err |-> reg_ack)
    else $error("error flag outside an answer");
  a_err_reads_zero: assert property (reg_err && $past(reg_rd) |-> reg_rdata == 64'h0)
    else $error("unmapped read returned data");
  a_rdata_holds: assert property ($past(rst_n) && !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_ps_tracks_halt: assert property ($past(rst_n) |-> core_power_save == $past(&lp_halted))
    else $error("power save does not follow both threads halted");
  a_awake_no_ps: assert property (!(&lp_halted) ##1 !(&lp_halted) |-> !core_power_save)
    else $error("power save while a thread runs");
  a_lp0_sample_src: assert property (precise_sample[0] |-> $past(evt_count[16] != 4'h0 && !evt_src_id0[16]))
    else $error("thread 0 sample without its event");
  a_lp1_sample_src: assert property (precise_sample[1] |-> $past(evt_count[17] != 4'h0 && evt_src_id0[17]))
    else $error("thread 1 sample without its event");
endmodule : tteq_counter_qualifier_asserts

bind tteq_counter_qualifier tteq_counter_qualifier_asserts #(
  .NUM_CTR(NUM_CTR)
) u_tteq_counter_qualifier_asserts (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
  .lp_halted(lp_halted), .evt_count(evt_count), .evt_src_id0(evt_src_id0),
  .precise_sample(precise_sample), .core_power_save(core_power_save)
);

`default_nettype wire

// ### bench/test_two_thread_event_counter_qualifier.sv
// Self-checking bench for the two-thread event counter qualifier.
// Assumes the one-cycle register answer and the thread model beside it.
`timescale 1ns/1ps
`default_nettype none

module test_two_thread_event_counter_qualifier
  import tteq_pkg::*;
;
  typedef struct {logic chk; logic err; logic [63:0] d;} tteq_note_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_lp = 1'b0;
  logic [11:0] reg_addr = '0;
  logic [63:0] reg_wdata = '0, reg_rdata;
  logic reg_ack, reg_err, core_power_save;
  logic [1:0][1:0] cmd_cpl = '0, lp_cpl;
  logic [1:0] cmd_halt = 2'h3, lp_halted, precise_sample;
  logic [3:0] halt_lag = 4'h0;
  logic [17:0][3:0] evt_count = '0;
  logic [17:0] evt_src_id0 = '0, evt_ts = '0;
  int n_mismatch = 0, compares = 0;
  tteq_note_t notes[$];
  logic [1:0] samples[$];

  always #10 sys_clk = ~sys_clk;

  tteq_counter_qualifier u_tteq_counter_qualifier (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_lp(reg_lp),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
    .lp_cpl(lp_cpl), .lp_halted(lp_halted), .evt_count(evt_count),
    .evt_src_id0(evt_src_id0), .evt_ts(evt_ts),
    .precise_sample(precise_sample), .core_power_save(core_power_save)
  );
  tteq_thread_model u_tteq_thread_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd_cpl(cmd_cpl),
    .cmd_halt(cmd_halt), .halt_lag(halt_lag), .lp_cpl(lp_cpl),
    .lp_halted(lp_halted)
  );

  // ==========================================================
  // shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // strobe stays up until the next call or idle, one access per cycle
  task automatic acc(input logic wr, input logic [11:0] a,
                     input logic [63:0] d, input logic [63:0] x,
                     input logic lp = 1'b0, input logic e = 1'b0);
    @(negedge sys_clk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    reg_lp = lp;
    notes.push_back('{!wr, e, x});
  endtask : acc

  task automatic idle(input int n);
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask : idle

  function automatic logic qual(input logic [3:0] f, input logic ts,
                                input logic src, input logic [1:0][1:0] c);
    logic u0, u1;
    u0 = c[0] != TTEQ_CPL_KERNEL;
    u1 = c[1] != TTEQ_CPL_KERNEL;
    if (ts) return src ? (u1 ? f[0] : f[1]) : (u0 ? f[2] : f[3]);
    return (f[2] & f[3]) | (f[0] & f[1]) | (f[2] & f[1]) | (f[3] & f[0])
      | ((f[2] | f[0]) & (u0 | u1)) | ((f[3] | f[1]) & !(u0 & u1));
  endfunction : qual

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // result monitor
  always @(negedge sys_clk) begin
    tteq_note_t n;
    if (rst_n && reg_ack === 1'b1) begin
      n = notes.pop_front();
      check({63'h0, reg_err}, {63'h0, n.err});
      if (n.chk) check(reg_rdata, n.d);
    end
    if (rst_n && precise_sample !== 2'h0) begin
      check({62'h0, precise_sample}, {62'h0, samples.pop_front()});
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end

  // ==========================================================
  // tests
  initial begin
    logic [3:0] v;
    logic src, w;
    logic [1:0] se, s, hit;
    logic [5:0] cls;
    int n;
    void'($urandom(32'hBE47));
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    cmd_halt <= 2'h0;
    acc(0, TTEQ_CFG_BASE, 0, TTEQ_CFG_RESET);
    acc(0, TTEQ_ESEL_BASE, 0, TTEQ_ESEL_RESET);
    acc(0, 12'hFFF, 0, 0, 0, 1);
    acc(1, TTEQ_CFG_BASE + 12'h2, 64'h1 << TTEQ_CFG_ENABLE_BIT, 0);
    for (int i = 0; i < 64; i++) begin
      src = 1'($urandom);
      v = 4'($urandom_range(15, 1));
      cmd_cpl <= 4'($urandom);
      acc(1, TTEQ_ESEL_BASE + 12'h2,
          (64'(TTEQ_CLASS_EXEC) << TTEQ_ESEL_CLASS_LSB) | 64'(i[3:0]), 0);
      acc(1, TTEQ_CTR_BASE + 12'h2, 0, 0);
      idle(2);
      evt_count[2] = v;
      evt_src_id0[2] = src;
      evt_ts[2] = i[4];
      repeat (4) @(negedge sys_clk);
      evt_count[2] = 4'h0;
      acc(0, TTEQ_CTR_BASE + 12'h2, 0, qual(i[3:0], i[4], src, cmd_cpl) ? {58'h0, v, 2'h0} : 64'h0);
    end
    idle(2);
    $display("test qualification done");
    acc(1, TTEQ_PRECISE_CFG_LP0, 64'h1 << TTEQ_CFG_ENABLE_BIT, 0);
    acc(1, TTEQ_PRECISE_CFG_LP1, 64'h1 << TTEQ_CFG_ENABLE_BIT, 0);
    for (int i = 0; i < 20; i++) begin
      cls = 6'(i % 5);
      w = 1'($urandom);
      se = 2'($urandom);
      s = 2'($urandom);
      acc(1, TTEQ_ESEL_BASE + 12'd16, (64'(cls) << TTEQ_ESEL_CLASS_LSB) | 64'hF, 0);
      acc(1, TTEQ_ESEL_BASE + 12'd17, (64'(cls) << TTEQ_ESEL_CLASS_LSB) | 64'hF, 0);
      acc(1, TTEQ_SAMPLE_EN_ADDR, {37'h0, se, 25'h0}, 0, w);
      acc(0, TTEQ_SAMPLE_EN_ADDR, 0, {37'h0, se[0], se[1], 25'h0}, !w);
      idle(1);
      hit[0] = cls >= TTEQ_CLASS_EXEC && (w ? se[1] : se[0]) && !s[0];
      hit[1] = cls >= TTEQ_CLASS_EXEC && (w ? se[0] : se[1]) && s[1];
      if (hit != 2'h0) samples.push_back(hit);
      evt_count[17:16] = {4'h1, 4'h1};
      evt_src_id0[17:16] = s;
      evt_ts[17:16] = 2'($urandom);
      @(negedge sys_clk);
      evt_count[17:16] = '0;
      repeat (3) @(negedge sys_clk);
      check(64'(samples.size()), 64'h0);
    end
    $display("test precise sampling done");
    acc(1, TTEQ_ESEL_BASE, (64'(TTEQ_CLASS_POWER) << TTEQ_ESEL_CLASS_LSB) | 64'h20F, 0);
    acc(1, TTEQ_ESEL_BASE + 12'h1, 64'(TTEQ_CLASS_POWER) << TTEQ_ESEL_CLASS_LSB, 0);
    acc(1, TTEQ_CFG_BASE, 64'h1 << TTEQ_CFG_ENABLE_BIT, 0);
    acc(1, TTEQ_CFG_BASE + 12'h1, 64'hFC1000, 0);
    for (int l = 0; l < 4; l += 3) begin
      halt_lag <= 4'(l);
      cmd_halt <= 2'h3;
      idle(8);
      acc(1, TTEQ_CTR_BASE, 0, 0);
      acc(1, TTEQ_CTR_BASE + 12'h1, 0, 0);
      idle(2);
      n = $urandom_range(12, 4);
      cmd_cpl <= 4'($urandom);
      cmd_halt <= 2'h2;
      repeat (n) @(negedge sys_clk);
      cmd_halt <= 2'h3;
      idle(8);
      acc(0, TTEQ_CTR_BASE, 0, 64'(n + l));
      acc(0, TTEQ_CTR_BASE + 12'h1, 0, 64'(n + l - 1));
    end
    idle(2);
    $display("test clock counting done");
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    acc(0, TTEQ_CFG_BASE, 0, TTEQ_CFG_RESET);
    idle(3);
    $display("test second reset done");
    final_report();
  end
endmodule : test_two_thread_event_counter_qualifier

`default_nettype wire
